// *** hw/otg_regs.svh ***
// otg event/status block: register offsets, field positions, resets, timing
// assumes byte addresses on a plain strobe port, one 32-bit word per register
`ifndef OTG_REGS_SVH
`define OTG_REGS_SVH

// ------------------------------------------------------------
// offsets
// ------------------------------------------------------------
`define OTG_ADDR_W        8
`define OTG_FLAGS_OFS     8'h00
`define OTG_ENABLES_OFS   8'h04
`define OTG_STATUS_OFS    8'h08
`define OTG_CTRL_OFS      8'h0C

// ------------------------------------------------------------
// field positions (event, enable and status share them)
// ------------------------------------------------------------
`define OTG_BIT_ID        7
`define OTG_BIT_MS        6
`define OTG_BIT_LINE      5
`define OTG_BIT_ACT       4
`define OTG_BIT_SESV      3
`define OTG_BIT_SEND      2
`define OTG_BIT_AVB       0
`define OTG_EVT_MASK      8'hFD
`define OTG_STAT_MASK     8'hAD
`define OTG_CTRL_WAKE     0

// sense vector positions after synchronising
`define OTG_SN_ID         0
`define OTG_SN_SESV       1
`define OTG_SN_SEND       2
`define OTG_SN_AVB        3
`define OTG_SN_SE0        4
`define OTG_SN_J          5
`define OTG_SN_DP         6
`define OTG_SN_DM         7

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define OTG_FLAGS_RST     8'h00
`define OTG_ENABLES_RST   8'h00
`define OTG_CTRL_RST      8'h00
`define OTG_MS_NS         1000000
`define OTG_CLK_NS        20
`define OTG_MS_CYCLES     ((`OTG_MS_NS + `OTG_CLK_NS - 1) / `OTG_CLK_NS)

`endif

// *** hw/otg_pkg.sv ***
// otg event/status block: shared types
// assumes otg_regs.svh for all numeric constants
package otg_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [31:0] word_t;
  typedef logic [1:0]  line_t;
endpackage

// *** hw/otg_sense_if.sv ***
// otg event/status block: bundle between synchroniser, line monitor and core
// assumes one clock domain on clk
`timescale 1ns/1ns
interface otg_sense_if;
  otg_pkg::byte_t lvl;
  otg_pkg::byte_t chg;
  logic           ms_tick;
  logic           settled;
  logic           settled_chg;
  modport sync (output lvl, output chg);
  modport mon  (input lvl, input chg, output ms_tick, output settled, output settled_chg);
  modport core (input lvl, input chg, input ms_tick, input settled, input settled_chg);
endinterface

// *** hw/otg_pin_sync.sv ***
// otg event/status block: two-flop synchronisers plus change pulses
// assumes raw pins are asynchronous to clk
`timescale 1ns/1ns
`include "otg_regs.svh"
module otg_pin_sync (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire otg_pkg::byte_t pins,
  otg_sense_if.sync           sense
);
  otg_pkg::byte_t meta_r;
  otg_pkg::byte_t sync_r;
  otg_pkg::byte_t prev_r;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
          prev_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= pins[i];
          sync_r[i] <= meta_r[i];
          prev_r[i] <= sync_r[i];
        end
      end
    end
  endgenerate

  // change pulses compare the second stage with its own history only
  assign sense.lvl = sync_r;
  assign sense.chg = sync_r ^ prev_r;
endmodule

// *** hw/otg_line_monitor.sv ***
// otg event/status block: free 1 ms tick and line-state settle detector
// assumes synchronised line levels on the sense bundle
`timescale 1ns/1ns
`include "otg_regs.svh"
module otg_line_monitor #(
  parameter int unsigned MS_CYCLES = `OTG_MS_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  otg_sense_if.mon  sense
);
  logic [31:0]    ms_cnt_r;
  logic [31:0]    st_cnt_r;
  logic           tick_r;
  logic           settled_r;
  logic           schg_r;
  otg_pkg::line_t line_prev_r;
  otg_pkg::line_t last_r;
  otg_pkg::line_t line;
  wire            ms_end  = (ms_cnt_r == 32'(MS_CYCLES - 1));
  wire            st_end  = (st_cnt_r == 32'(MS_CYCLES - 1));
  wire            moved   = (line != line_prev_r);

  assign line = {sense.lvl[`OTG_SN_SE0], sense.lvl[`OTG_SN_J]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_cnt_r <= 32'h0;
      tick_r   <= 1'b0;
    end else begin
      ms_cnt_r <= ms_end ? 32'h0 : ms_cnt_r + 32'h1;
      tick_r   <= ms_end;
    end
  end

  // settle window restarts on every movement of the line pair
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_cnt_r    <= 32'h0;
      settled_r   <= 1'b0;
      schg_r      <= 1'b0;
      line_prev_r <= 2'h0;
      last_r      <= 2'h0;
    end else begin
      line_prev_r <= line;
      schg_r      <= 1'b0;
      if (moved) begin
        st_cnt_r  <= 32'h0;
        settled_r <= 1'b0;
      end else if (!st_end) begin
        st_cnt_r <= st_cnt_r + 32'h1;
      end else if (!settled_r) begin
        settled_r <= 1'b1;
        schg_r    <= (line != last_r);
        last_r    <= line;
      end
    end
  end

  assign sense.ms_tick     = tick_r;
  assign sense.settled     = settled_r;
  assign sense.settled_chg = schg_r;
endmodule

// *** hw/otg_event_status.sv ***
// otg event/status block: sticky events, enables, live status, one irq
// assumes a single-clock strobe bus master and asynchronous cable/vbus pins
`timescale 1ns/1ns
`include "otg_regs.svh"
module otg_event_status #(
  parameter int unsigned MS_CYCLES = `OTG_MS_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [`OTG_ADDR_W-1:0]   addr,
  input  wire otg_pkg::word_t           wdata,
  input  wire logic                     wr_stb,
  input  wire logic                     rd_stb,
  output otg_pkg::word_t                rdata,
  output logic                          irq,
  input  wire logic                     id_pin,
  input  wire logic                     sess_valid_in,
  input  wire logic                     sess_end_in,
  input  wire logic                     a_vbus_valid_in,
  input  wire logic                     se0_in,
  input  wire logic                     line_j_indication,
  input  wire logic                     dp_pin,
  input  wire logic                     dm_pin
);

  // ------------------------------------------------------------
  // sensing
  // ------------------------------------------------------------
  otg_sense_if sense ();
  otg_pkg::byte_t raw_pins;

  assign raw_pins[`OTG_SN_ID]   = id_pin;
  assign raw_pins[`OTG_SN_SESV] = sess_valid_in;
  assign raw_pins[`OTG_SN_SEND] = sess_end_in;
  assign raw_pins[`OTG_SN_AVB]  = a_vbus_valid_in;
  assign raw_pins[`OTG_SN_SE0]  = se0_in;
  assign raw_pins[`OTG_SN_J]    = line_j_indication;
  assign raw_pins[`OTG_SN_DP]   = dp_pin;
  assign raw_pins[`OTG_SN_DM]   = dm_pin;

  otg_pin_sync u_sync (
    .clk   (clk),
    .rst   (rst),
    .pins  (raw_pins),
    .sense (sense)
  );

  otg_line_monitor #(
    .MS_CYCLES (MS_CYCLES)
  ) u_mon (
    .clk   (clk),
    .rst   (rst),
    .sense (sense)
  );

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  otg_pkg::byte_t flags_r;
  otg_pkg::byte_t flags_nxt;
  otg_pkg::byte_t enables_r;
  otg_pkg::byte_t enables_nxt;
  otg_pkg::byte_t ctrl_r;
  otg_pkg::byte_t ctrl_nxt;
  otg_pkg::byte_t status;
  otg_pkg::byte_t hw_set;
  otg_pkg::byte_t sw_clr;
  otg_pkg::word_t rdata_r;
  otg_pkg::word_t rd_word;
  logic           irq_r;

  // address decode shared by the write and read paths
  function automatic logic hit(input logic [`OTG_ADDR_W-1:0] a,
                               input logic [`OTG_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  wire sel_flags = hit(addr, `OTG_FLAGS_OFS);
  wire sel_en    = hit(addr, `OTG_ENABLES_OFS);
  wire sel_stat  = hit(addr, `OTG_STATUS_OFS);
  wire sel_ctrl  = hit(addr, `OTG_CTRL_OFS);

  wire wr_flags  = wr_stb && sel_flags;
  wire wr_en     = wr_stb && sel_en;
  wire wr_ctrl   = wr_stb && sel_ctrl;

  // ------------------------------------------------------------
  // live status
  // ------------------------------------------------------------
  // no slack: id, session and vbus bits read straight from the synchronised levels, line bit from the settle detector
  assign status[`OTG_BIT_ID]   = sense.lvl[`OTG_SN_ID];
  assign status[6]             = 1'b0;
  assign status[`OTG_BIT_LINE] = sense.settled;
  assign status[4]             = 1'b0;
  assign status[`OTG_BIT_SESV] = sense.lvl[`OTG_SN_SESV];
  assign status[`OTG_BIT_SEND] = sense.lvl[`OTG_SN_SEND];
  assign status[1]             = 1'b0;
  assign status[`OTG_BIT_AVB]  = sense.lvl[`OTG_SN_AVB];

  // ------------------------------------------------------------
  // event sources
  // ------------------------------------------------------------
  wire wake_armed = ctrl_r[`OTG_CTRL_WAKE];
  wire pin_moved  = sense.chg[`OTG_SN_DP]   | sense.chg[`OTG_SN_DM]   |
                    sense.chg[`OTG_SN_ID]   | sense.chg[`OTG_SN_SESV] |
                    sense.chg[`OTG_SN_SEND] | sense.chg[`OTG_SN_AVB];
  wire send_rise  = sense.chg[`OTG_SN_SEND] & sense.lvl[`OTG_SN_SEND];

  assign hw_set[`OTG_BIT_ID]   = sense.chg[`OTG_SN_ID];
  assign hw_set[`OTG_BIT_MS]   = sense.ms_tick;
  assign hw_set[`OTG_BIT_LINE] = sense.settled_chg;
  assign hw_set[`OTG_BIT_ACT]  = wake_armed & pin_moved;
  assign hw_set[`OTG_BIT_SESV] = send_rise;
  assign hw_set[`OTG_BIT_SEND] = sense.chg[`OTG_SN_SEND];
  assign hw_set[1]             = 1'b0;
  assign hw_set[`OTG_BIT_AVB]  = sense.chg[`OTG_SN_AVB];

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  // a set in the clearing cycle survives, so no event is lost
  assign sw_clr      = wr_flags ? wdata[7:0] : 8'h00;
  assign flags_nxt   = ((flags_r & ~sw_clr) | hw_set) & `OTG_EVT_MASK;
  assign enables_nxt = wr_en ? (wdata[7:0] & `OTG_EVT_MASK) : enables_r;
  assign ctrl_nxt    = wr_ctrl ? {7'h00, wdata[`OTG_CTRL_WAKE]} : ctrl_r;

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // unmapped addresses read zero; upper 24 bits are always zero
  assign rd_word = {24'h000000,
                    (sel_flags ? flags_r   : 8'h00) |
                    (sel_en    ? enables_r : 8'h00) |
                    (sel_stat  ? status    : 8'h00) |
                    (sel_ctrl  ? ctrl_r    : 8'h00)};

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_r   <= `OTG_FLAGS_RST;
      enables_r <= `OTG_ENABLES_RST;
      ctrl_r    <= `OTG_CTRL_RST;
    end else begin
      flags_r   <= flags_nxt;
      enables_r <= enables_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rd_stb ? rd_word : 32'h00000000;
    end
  end

  // computed from next values so irq tracks the registers exactly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flags_nxt & enables_nxt);
    end
  end

  assign rdata = rdata_r;
  assign irq   = irq_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // long windows are counted here, since delays that long would unroll badly
  logic [31:0]    tick_gap_r;
  logic           tick_seen_r;
  logic [31:0]    quiet_r;
  otg_pkg::line_t pair_prev_r;
  otg_pkg::line_t pair;

  assign pair = {sense.lvl[`OTG_SN_SE0], sense.lvl[`OTG_SN_J]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_gap_r  <= 32'h00000000;
      tick_seen_r <= 1'b0;
    end else if (sense.ms_tick) begin
      tick_gap_r  <= 32'h00000000;
      tick_seen_r <= 1'b1;
    end else begin
      tick_gap_r  <= tick_gap_r + 32'h00000001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_r     <= 32'h00000000;
      pair_prev_r <= 2'h0;
    end else begin
      pair_prev_r <= pair;
      if (pair != pair_prev_r) begin
        quiet_r <= 32'h00000000;
      end else if (quiet_r != 32'hFFFFFFFF) begin
        quiet_r <= quiet_r + 32'h00000001;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_read_flags;
    rd_stb && sel_flags;
  endsequence

  sequence s_clear_one(int b);
    wr_flags && wdata[b] && !hw_set[b];
  endsequence

  sequence s_line_resettled;
    $rose(sense.settled) ##0 sense.settled_chg;
  endsequence

  sequence s_last_pair_cleared;
    wr_flags && !wr_en && (((flags_r & ~wdata[7:0]) | hw_set) & enables_r) == 8'h00;
  endsequence

  a_irq_tracks_pairs: assert property (
    irq == |(flags_r & enables_r))
    else $error("irq differs from flag and enable pairs");

  a_read_upper_zero: assert property (
    rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  a_bit1_reads_zero: assert property (
    rd_stb |=> rdata[1] == 1'b0)
    else $error("bit 1 read as one");

  a_read_one_cycle: assert property (
    s_read_flags |=> (rdata[7:0] == $past(flags_r)) ##1 (rdata == 32'h0 || $past(rd_stb)))
    else $error("flag read data wrong or held too long");

  a_clear_on_one: assert property (
    s_clear_one(`OTG_BIT_ID) |=> !flags_r[`OTG_BIT_ID])
    else $error("write one did not clear flag");

  a_set_wins_clear: assert property (
    (wr_flags && wdata[`OTG_BIT_MS] && sense.ms_tick) |=> flags_r[`OTG_BIT_MS])
    else $error("clear beat a simultaneous set");

  a_zero_write_keeps: assert property (
    (wr_flags && flags_r[`OTG_BIT_AVB] && !wdata[`OTG_BIT_AVB]) |=> flags_r[`OTG_BIT_AVB])
    else $error("writing zero changed a flag");

  a_id_change_flag: assert property (
    $changed(status[`OTG_BIT_ID]) |=> flags_r[`OTG_BIT_ID])
    else $error("id change not flagged");

  a_ms_tick_flag: assert property (
    sense.ms_tick |=> flags_r[`OTG_BIT_MS])
    else $error("timer expiry not flagged");

  a_sess_end_flags: assert property (
    $rose(status[`OTG_BIT_SEND]) |=> flags_r[`OTG_BIT_SEND] && flags_r[`OTG_BIT_SESV])
    else $error("session end rise not flagged");

  a_vbus_change_flag: assert property (
    $changed(status[`OTG_BIT_AVB]) |=> flags_r[`OTG_BIT_AVB])
    else $error("a-device vbus change not flagged");

  a_line_stable_hold: assert property (
    $fell(status[`OTG_BIT_LINE]) |-> $past(sense.lvl[`OTG_SN_SE0]) != $past(sense.lvl[`OTG_SN_SE0], 2)
      || $past(sense.lvl[`OTG_SN_J]) != $past(sense.lvl[`OTG_SN_J], 2))
    else $error("settled status dropped without line movement");

  a_enable_write: assert property (
    wr_en |=> enables_r == ($past(wdata[7:0]) & `OTG_EVT_MASK))
    else $error("enable write not stored");

  a_flags_held_still: assert property (
    (!wr_flags && hw_set == 8'h00) |=> flags_r == $past(flags_r))
    else $error("flags moved without an event or a clear");

  a_line_flag_set: assert property (
    s_line_resettled |=> flags_r[`OTG_BIT_LINE])
    else $error("new settled line value not flagged");

  a_wake_flag_set: assert property (
    (wake_armed && ($changed(sense.lvl[`OTG_SN_DP]) || $changed(sense.lvl[`OTG_SN_DM]))) |=> flags_r[`OTG_BIT_ACT])
    else $error("armed pin activity not flagged");

  a_wake_needs_arm: assert property (
    $rose(flags_r[`OTG_BIT_ACT]) |-> $past(wake_armed))
    else $error("activity flagged while not armed");

  a_send_change_flag: assert property (
    $changed(status[`OTG_BIT_SEND]) |=> flags_r[`OTG_BIT_SEND])
    else $error("session end change not flagged");

  a_sesv_flag_cause: assert property (
    $rose(flags_r[`OTG_BIT_SESV]) |-> $past(status[`OTG_BIT_SEND]) && !$past(status[`OTG_BIT_SEND], 2))
    else $error("session valid flag without a drop below session end");

  a_id_level_synced: assert property (
    !$past(rst, 3) |-> status[`OTG_BIT_ID] == $past(id_pin, 2))
    else $error("cable id status does not follow the pin");

  a_sesv_level_synced: assert property (
    !$past(rst, 3) |-> status[`OTG_BIT_SESV] == $past(sess_valid_in, 2))
    else $error("session valid status does not follow the comparator");

  a_send_level_synced: assert property (
    !$past(rst, 3) |-> status[`OTG_BIT_SEND] == $past(sess_end_in, 2))
    else $error("session end status does not follow the comparator");

  a_avb_level_synced: assert property (
    !$past(rst, 3) |-> status[`OTG_BIT_AVB] == $past(a_vbus_valid_in, 2))
    else $error("a-device vbus status does not follow the comparator");

  a_irq_drops_clear: assert property (
    s_last_pair_cleared |=> !irq)
    else $error("irq stayed high after the last pair was cleared");

  a_ms_tick_period: assert property (
    (sense.ms_tick && tick_seen_r) |-> tick_gap_r == 32'(MS_CYCLES - 1))
    else $error("timer period wrong");

  a_settled_needs_quiet: assert property (
    status[`OTG_BIT_LINE] |-> quiet_r >= 32'(MS_CYCLES))
    else $error("line settled before a full quiet window");

  a_quiet_gives_settled: assert property (
    quiet_r >= 32'(MS_CYCLES) |-> status[`OTG_BIT_LINE])
    else $error("line quiet a full window but not settled");

endmodule

// *** test/otg_cable_model.sv ***
// cable, transceiver and vbus comparator model for the otg event block
// assumes the bench calls drive_lines from its own thread, clk at 50 MHz
`timescale 1ns/1ns
module otg_cable_model (
  input  wire logic clk,
  output logic      id_pin,
  output logic      sess_valid_in,
  output logic      sess_end_in,
  output logic      a_vbus_valid_in,
  output logic      se0_in,
  output logic      line_j_indication,
  output logic      dp_pin,
  output logic      dm_pin
);
  // ------------------------------------------------------------
  // line levels
  // ------------------------------------------------------------
  // packed {dm, dp, j, se0, a_vbus, sess_end, sess_valid, id}
  // comparators always drive a level, so no released state exists
  logic [7:0] lv_r = 8'h05;

  assign {dm_pin, dp_pin, line_j_indication, se0_in} = lv_r[7:4];
  assign {a_vbus_valid_in, sess_end_in, sess_valid_in, id_pin} = lv_r[3:0];

  // levels move just after an edge, as a real cable would not align to it anyway
  task automatic drive_lines(input logic [7:0] v);
    @(posedge clk);
    lv_r <= v;
  endtask
endmodule

// *** test/testbench.sv ***
// self-checking bench for the otg event/status block
// assumes the strobe register bus and the offsets of otg_regs.svh
`timescale 1ns/1ns
`include "otg_regs.svh"
module testbench;
  localparam int unsigned MS = 40;
  localparam logic [31:0] NO6 = 32'hFFFF_FFBF;
  localparam logic [31:0] NO5 = 32'hFFFF_FFDF;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic [`OTG_ADDR_W-1:0] addr = 8'h00;
  otg_pkg::word_t         wdata = 32'h0;
  logic                   wr_stb = 1'b0;
  logic                   rd_stb = 1'b0;
  otg_pkg::word_t         rdata;
  logic                   irq;
  logic                   id_pin, sess_valid_in, sess_end_in, a_vbus_valid_in;
  logic                   se0_in, line_j_indication, dp_pin, dm_pin;
  int                     errors = 0;
  int                     cmp_count = 0;
  int                     n;
  logic [7:0]             lv [6] = '{8'h04, 8'h0C, 8'h0E, 8'h0A, 8'h0E, 8'h0F};
  logic [31:0]            ef [6] = '{32'h80, 32'h01, 32'h00, 32'h04, 32'h0C, 32'h80};
  logic [31:0]            es [6] = '{32'h04, 32'h05, 32'h0D, 32'h09, 32'h0D, 32'h8D};

  otg_event_status #(.MS_CYCLES(MS)) u_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .irq(irq), .id_pin(id_pin), .sess_valid_in(sess_valid_in),
    .sess_end_in(sess_end_in), .a_vbus_valid_in(a_vbus_valid_in), .se0_in(se0_in),
    .line_j_indication(line_j_indication), .dp_pin(dp_pin), .dm_pin(dm_pin));

  otg_cable_model u_cable (
    .clk(clk), .id_pin(id_pin), .sess_valid_in(sess_valid_in), .sess_end_in(sess_end_in),
    .a_vbus_valid_in(a_vbus_valid_in), .se0_in(se0_in), .line_j_indication(line_j_indication),
    .dp_pin(dp_pin), .dm_pin(dm_pin));

  initial begin
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input otg_pkg::word_t d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input otg_pkg::word_t msk, input otg_pkg::word_t exp);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata & msk, exp);
  endtask

  task automatic chk(input otg_pkg::word_t got, input otg_pkg::word_t exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic irq_chk(input logic exp);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // bounded wait for the interrupt; n counts edges taken
  task automatic wait_irq(input int max, output int cnt);
    for (cnt = 1; cnt <= max; cnt++) begin
      @(posedge clk);
      #1;
      if (irq === 1'b1) begin
        return;
      end
    end
    errors++;
    $display("BAD t=%0t irq wait got=%h exp=%h", $time, irq, 1'b1);
    print_verdict();
  endtask

  task automatic print_verdict();
    $display("comparisons=%0d errors=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`OTG_ENABLES_OFS, 32'hFFFF_FFFF, 32'h0);
    repeat (6) @(posedge clk);
    rd_chk(`OTG_STATUS_OFS, NO5, 32'h84);
    // synchronisers leave reset at 0, so id and session end show as changes
    rd_chk(`OTG_FLAGS_OFS, NO6, 32'h8C);
    wr(`OTG_FLAGS_OFS, 32'h0);
    rd_chk(`OTG_FLAGS_OFS, NO6, 32'h8C);
    wr(`OTG_FLAGS_OFS, 32'hFFFF_FFFF);
    rd_chk(`OTG_FLAGS_OFS, NO6, 32'h0);
    wr(`OTG_ENABLES_OFS, 32'hFFFF_FFFF);
    rd_chk(`OTG_ENABLES_OFS, 32'hFFFF_FFFF, 32'hFD);
    wr(`OTG_ENABLES_OFS, 32'h0);
    wr(`OTG_STATUS_OFS, 32'hFFFF_FFFF);
    rd_chk(`OTG_STATUS_OFS, NO5, 32'h84);
    wr(8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'hFFFF_FFFF, 32'h0);
    for (int i = 0; i < 6; i++) begin
      u_cable.drive_lines(lv[i]);
      repeat (5) @(posedge clk);
      rd_chk(`OTG_FLAGS_OFS, NO6, ef[i]);
      rd_chk(`OTG_STATUS_OFS, NO5, es[i]);
      wr(`OTG_FLAGS_OFS, 32'hFFFF_FFFF);
    end
    u_cable.drive_lines(8'h0E);
    repeat (5) @(posedge clk);
    irq_chk(1'b0);
    wr(`OTG_ENABLES_OFS, 32'h80);
    irq_chk(1'b1);
    wr(`OTG_FLAGS_OFS, 32'h7F);
    irq_chk(1'b1);
    wr(`OTG_FLAGS_OFS, 32'h80);
    irq_chk(1'b0);
    // timer period seen between two interrupt rises, clear in between
    wr(`OTG_ENABLES_OFS, 32'h40);
    wr(`OTG_FLAGS_OFS, 32'hFFFF_FFFF);
    wait_irq(MS + 4, n);
    wr(`OTG_FLAGS_OFS, 32'h40);
    wait_irq(MS + 4, n);
    chk(otg_pkg::word_t'(n), otg_pkg::word_t'(MS - 2));
    wr(`OTG_ENABLES_OFS, 32'h20);
    wr(`OTG_FLAGS_OFS, 32'hFFFF_FFFF);
    u_cable.drive_lines(8'h2E);
    wait_irq(MS + 10, n);
    chk(otg_pkg::word_t'(n >= MS && n <= MS + 6), 32'h1);
    rd_chk(`OTG_STATUS_OFS, 32'h20, 32'h20);
    wr(`OTG_FLAGS_OFS, 32'hFFFF_FFFF);
    // short glitch, line returns to the value already settled
    u_cable.drive_lines(8'h3E);
    u_cable.drive_lines(8'h2E);
    repeat (3) @(posedge clk);
    rd_chk(`OTG_STATUS_OFS, 32'h20, 32'h0);
    repeat (MS + 10) @(posedge clk);
    irq_chk(1'b0);
    wr(`OTG_CTRL_OFS, 32'h1);
    wr(`OTG_ENABLES_OFS, 32'h10);
    wr(`OTG_FLAGS_OFS, 32'hFFFF_FFFF);
    u_cable.drive_lines(8'h6E);
    wait_irq(8, n);
    rd_chk(`OTG_FLAGS_OFS, 32'h10, 32'h10);
    print_verdict();
  end
endmodule
